// ---- logic/chgctl_core.sv ----
`timescale 1ns/1ps
// Operation
// - otg off, switch enabled, standby requested: battery switch on, converter off
// - otg off, switch disabled by pin or bit: switch off, converter standby or state machine
// - otg off, disable pin high, input invalid, standby low: ship mode, both off
// - otg active: battery switch on, converter by state machine, except ship mode
// - mode field equal to otg code acts like otg pin high
// - battery switch disabled by pin or bit stops charging
// - thermistor cold or hot stops charging and resets charge timers
// - thermistor suspension updates detail code, charge good flag, sets charge event irq
// - thermistor back in range resumes charging and restarts the timer
// - temperature profile applied only while enable bit is one
// - grounded thermistor: no monitoring, no profile, battery present, autostart
// - thermistor tied to analog rail: battery removed, no charging
// - four valid strap resistors: defaults come from decoded resistors
// - four straps on bias rail: built-in defaults loaded
// - other strap mix: converter regulates, charging disabled, indicator shows none
// - input current limit decoded from strap per resistor table, bias 500 mA
// - host may overwrite 7-bit input limit field, then applied
// - fast charge current decoded like input limit, bias gives 450 mA
// - host may overwrite high bit and 8-bit fast charge field
// - top-off threshold decoded from strap per table, bias 25 mA
// - host may overwrite 3-bit top-off threshold field
// - termination voltage field preset from strap, host may overwrite
module chgctl_core
  import chgctl_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys_in,
  input  wire logic           rst_in,
  // control pins (asynchronous)
  input  wire logic           otg_request_pin_in,
  input  wire logic           battery_switch_disable_pin_in,
  input  wire logic           standby_pin_in,
  input  wire logic           charger_input_valid_in,
  // host control bits (clock domain)
  input  wire logic [3:0]     mode_field_in,
  input  wire logic           battery_switch_disable_bit_in,
  input  wire logic           standby_enable_bit_in,
  input  wire logic           temp_profile_enable_in,
  input  wire logic           charge_enable_bit_in,
  input  wire logic           charge_event_irq_clear_in,
  // power-path state machine requests (clock domain)
  input  wire logic           pp_converter_on_in,
  input  wire logic           pp_switch_on_in,
  // thermistor classification (asynchronous)
  input  wire chgctl_thm_e    thermistor_input_in,
  // straps (valid after reset release)
  input  wire chgctl_strap_s  input_limit_strap_in,
  input  wire chgctl_strap_s  fast_charge_strap_in,
  input  wire chgctl_strap_s  topoff_strap_in,
  input  wire chgctl_strap_s  termination_voltage_strap_in,
  // host parameter writes
  input  wire logic           wr_input_limit_in,
  input  wire logic           wr_fast_charge_in,
  input  wire logic           wr_topoff_in,
  input  wire logic           wr_term_voltage_in,
  input  wire chgctl_params_s wr_data_in,
  // outputs
  output logic                battery_system_switch_out,
  output logic                converter_enable_out,
  output logic                ship_mode_out,
  output logic                charge_enable_out,
  output logic                charge_timer_reset_out,
  output logic                temp_profile_active_out,
  output logic                battery_present_out,
  output logic [3:0]          charge_detail_code_out,
  output logic                charge_good_flag_out,
  output logic                charge_event_irq_out,
  output logic                charging_indicator_out,
  output logic                params_loaded_out,
  output chgctl_cfg_e         strap_config_out,
  output chgctl_params_s      params_out
);

  // ==========================================================
  // input synchronisers
  logic [3:0]  pin_meta;
  logic [3:0]  pin_sync;
  chgctl_thm_e thm_meta;
  chgctl_thm_e thm_sync;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      thm_meta <= CHGCTL_THM_NORMAL;
      thm_sync <= CHGCTL_THM_NORMAL;
    end else begin
      pin_meta <= {otg_request_pin_in, battery_switch_disable_pin_in,
                   standby_pin_in, charger_input_valid_in};
      pin_sync <= pin_meta;
      thm_meta <= thermistor_input_in;
      thm_sync <= thm_meta;
    end
  end

  logic otg_pin;
  logic dis_pin;
  logic standby_pin_pin;
  logic cin_valid;
  assign {otg_pin, dis_pin, standby_pin_pin, cin_valid} = pin_sync;

  // ==========================================================
  // strap decode
  function automatic logic [7:0] cur_code(input logic [3:0] idx);
    logic [7:0] code;
    code = 8'h00;
    case (idx)
      4'h0: code = 8'h01;
      4'h1: code = 8'h02;
      4'h2: code = 8'h04;
      4'h3: code = 8'h0A;
      4'h4: code = 8'h14;
      4'h5: code = 8'h1E;
      4'h6: code = 8'h28;
      4'h7: code = 8'h32;
      4'h8: code = 8'h3C;
      default: code = 8'h00;
    endcase
    return code;
  endfunction

  function automatic logic [2:0] ito_code(input logic [3:0] idx);
    logic [2:0] code;
    code = 3'h0;
    case (idx)
      4'h0: code = 3'h0;
      4'h1: code = 3'h1;
      4'h2: code = 3'h2;
      4'h3: code = 3'h3;
      4'h4: code = 3'h4;
      4'h5: code = 3'h5;
      4'h6: code = 3'h6;
      4'h7: code = 3'h7;
      default: code = 3'h0;
    endcase
    return code;
  endfunction

  chgctl_strap_s straps [4];
  assign straps[0] = input_limit_strap_in;
  assign straps[1] = fast_charge_strap_in;
  assign straps[2] = topoff_strap_in;
  assign straps[3] = termination_voltage_strap_in;

  localparam logic [3:0] CNT_LIM [4] = '{4'(CHGCTL_CUR_RES_CNT - 1),
                                         4'(CHGCTL_CUR_RES_CNT - 1),
                                         4'(CHGCTL_ITO_RES_CNT - 1),
                                         4'(CHGCTL_TERMINATION_VOLTAGE_STRAP_RES_CNT - 1)};

  logic [3:0] strap_res;
  logic [3:0] strap_bias;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strap
      assign strap_res[gi]  = (straps[gi].kind == CHGCTL_STRAP_RES) &&
                              (straps[gi].idx <= CNT_LIM[gi]);
      assign strap_bias[gi] = (straps[gi].kind == CHGCTL_STRAP_BIAS);
    end
  endgenerate

  chgctl_cfg_e    next_cfg;
  chgctl_params_s next_defaults;
  logic [7:0]     ilim_c;
  logic [7:0]     ichg_c;

  always_comb begin
    ilim_c = cur_code(input_limit_strap_in.idx);
    ichg_c = cur_code(fast_charge_strap_in.idx);
    next_defaults = '0;
    if (&strap_res) begin
      next_cfg = CHGCTL_CFG_RESISTOR;
      next_defaults.input_current_limit_field = ilim_c[6:0];
      next_defaults.fast_charge_current_field = ichg_c;
      next_defaults.topoff_threshold_field = ito_code(topoff_strap_in.idx);
      next_defaults.termination_voltage_field =
        8'(termination_voltage_strap_in.idx) + 8'h01;
    end else if (&strap_bias) begin
      next_cfg = CHGCTL_CFG_DEFAULT;
      next_defaults.input_current_limit_field =
        7'(CHGCTL_ILIM_BIAS_MA / CHGCTL_CUR_LSB_MA);
      next_defaults.fast_charge_current_field =
        8'(CHGCTL_ICHG_BIAS_MA / CHGCTL_CUR_LSB_MA);
      next_defaults.topoff_threshold_field = CHGCTL_ITO_BIAS_CODE;
      next_defaults.termination_voltage_field = CHGCTL_TERMINATION_VOLTAGE_STRAP_BIAS_CODE;
    end else begin
      next_cfg = CHGCTL_CFG_ABNORMAL;
    end
  end

  // ==========================================================
  // parameter registers: one strap load after reset, then host writes
  logic           loaded;
  chgctl_cfg_e    cfg;
  chgctl_params_s params;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      loaded <= 1'b0;
      cfg    <= CHGCTL_CFG_ABNORMAL;
      params <= '0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      cfg    <= next_cfg;
      params <= next_defaults;
    end else begin
      if (wr_input_limit_in) begin
        params.input_current_limit_field <= wr_data_in.input_current_limit_field;
      end
      if (wr_fast_charge_in) begin
        params.fast_charge_current_high_bit <= wr_data_in.fast_charge_current_high_bit;
        params.fast_charge_current_field <= wr_data_in.fast_charge_current_field;
      end
      if (wr_topoff_in) begin
        params.topoff_threshold_field <= wr_data_in.topoff_threshold_field;
      end
      if (wr_term_voltage_in) begin
        params.termination_voltage_field <= wr_data_in.termination_voltage_field;
      end
    end
  end

  // ==========================================================
  // battery switch and converter control
  logic otg_req;
  logic sw_dis;
  logic standby_pin_req;
  logic ship;

  assign otg_req  = otg_pin || (mode_field_in == CHGCTL_MODE_OTG);
  assign sw_dis   = dis_pin || battery_switch_disable_bit_in;
  assign standby_pin_req = standby_pin_pin || standby_enable_bit_in;
  assign ship     = dis_pin && !cin_valid && !standby_pin_pin;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      battery_system_switch_out <= 1'b0;
      converter_enable_out      <= 1'b0;
      ship_mode_out             <= 1'b0;
    end else begin
      ship_mode_out <= ship;
      if (ship) begin
        battery_system_switch_out <= 1'b0;
        converter_enable_out      <= 1'b0;
      end else if (otg_req) begin
        battery_system_switch_out <= 1'b1;
        converter_enable_out      <= pp_converter_on_in;
      end else if (sw_dis) begin
        battery_system_switch_out <= 1'b0;
        converter_enable_out      <= standby_pin_req ? 1'b0 : pp_converter_on_in;
      end else if (standby_pin_req) begin
        battery_system_switch_out <= 1'b1;
        converter_enable_out      <= 1'b0;
      end else begin
        battery_system_switch_out <= pp_switch_on_in;
        converter_enable_out      <= pp_converter_on_in;
      end
    end
  end

  // ==========================================================
  // thermistor and charge enable
  logic thm_out_rng;
  logic thm_ground;
  logic thm_rail;
  logic thm_susp;
  logic charge_good_flag;

  assign thm_ground  = (thm_sync == CHGCTL_THM_GROUND);
  assign thm_rail    = (thm_sync == CHGCTL_THM_RAIL);
  assign thm_out_rng = (thm_sync == CHGCTL_THM_COLD) || (thm_sync == CHGCTL_THM_HOT);
  // grounded thermistor always counts as present and stands in for the charge enable bit
  assign charge_good_flag = loaded && (cfg != CHGCTL_CFG_ABNORMAL) &&
                  !sw_dis && !ship && !otg_req &&
                  !thm_rail && cin_valid &&
                  (charge_enable_bit_in || thm_ground);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      thm_susp               <= 1'b0;
      charge_enable_out      <= 1'b0;
      charge_timer_reset_out <= 1'b0;
      battery_present_out    <= 1'b0;
      temp_profile_active_out <= 1'b0;
    end else begin
      thm_susp <= thm_out_rng;
      // timer restarts on entry and exit of a suspension
      charge_timer_reset_out <= thm_out_rng || (thm_susp && !thm_out_rng);
      charge_enable_out      <= charge_good_flag && !thm_out_rng;
      battery_present_out    <= !thm_rail;
      temp_profile_active_out <= temp_profile_enable_in && !thm_ground;
    end
  end

  // ==========================================================
  // status and charge event
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      charge_detail_code_out <= CHGCTL_DTL_OFF;
      charge_good_flag_out   <= 1'b0;
      charge_event_irq_out   <= 1'b0;
    end else begin
      if (thm_out_rng && charge_good_flag) begin
        charge_detail_code_out <= CHGCTL_DTL_THM_SUSP;
        charge_good_flag_out   <= 1'b0;
      end else if (charge_good_flag) begin
        charge_detail_code_out <= CHGCTL_DTL_CHARGING;
        charge_good_flag_out   <= 1'b1;
      end else begin
        charge_detail_code_out <= CHGCTL_DTL_OFF;
        charge_good_flag_out   <= 1'b0;
      end
      // set wins over clear
      if (thm_out_rng && !thm_susp) begin
        charge_event_irq_out <= 1'b1;
      end else if (charge_event_irq_clear_in) begin
        charge_event_irq_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register mirrors
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      charging_indicator_out <= 1'b0;
      params_loaded_out      <= 1'b0;
      strap_config_out       <= CHGCTL_CFG_ABNORMAL;
      params_out             <= '0;
    end else begin
      charging_indicator_out <= charge_good_flag && !thm_out_rng;
      params_loaded_out      <= loaded;
      strap_config_out       <= cfg;
      params_out             <= params;
    end
  end

endmodule

// ---- logic/chgctl_pkg.sv ----
package chgctl_pkg;

  // ==========================================================
  // strap classification as delivered by the analog decoder
  typedef enum logic [1:0] {
    CHGCTL_STRAP_BIAS    = 2'b00,
    CHGCTL_STRAP_RES     = 2'b01,
    CHGCTL_STRAP_OPEN    = 2'b10,
    CHGCTL_STRAP_INVALID = 2'b11
  } chgctl_strap_kind_e;

  // one strap input: kind plus resistor table index (0 = 226k ... 14 = 5.49k)
  typedef struct packed {
    chgctl_strap_kind_e kind;
    logic [3:0]         idx;
  } chgctl_strap_s;

  // thermistor classification from the analog front end
  typedef enum logic [2:0] {
    CHGCTL_THM_NORMAL = 3'b000,
    CHGCTL_THM_COLD   = 3'b001,
    CHGCTL_THM_HOT    = 3'b010,
    CHGCTL_THM_GROUND = 3'b011,
    CHGCTL_THM_RAIL   = 3'b100
  } chgctl_thm_e;

  // strap decode result
  typedef enum logic [1:0] {
    CHGCTL_CFG_RESISTOR = 2'b00,
    CHGCTL_CFG_DEFAULT  = 2'b01,
    CHGCTL_CFG_ABNORMAL = 2'b10
  } chgctl_cfg_e;

  // charge-parameter register set
  typedef struct packed {
    logic [6:0] input_current_limit_field;
    logic       fast_charge_current_high_bit;
    logic [7:0] fast_charge_current_field;
    logic [2:0] topoff_threshold_field;
    logic [7:0] termination_voltage_field;
  } chgctl_params_s;

  // ==========================================================
  // mode field code for reverse mode
  localparam logic [3:0] CHGCTL_MODE_OTG = 4'hA;

  // charge detail codes
  localparam logic [3:0] CHGCTL_DTL_CHARGING = 4'h1;
  localparam logic [3:0] CHGCTL_DTL_THM_SUSP = 4'hA;
  localparam logic [3:0] CHGCTL_DTL_OFF      = 4'h8;

  // current values are in mA; fields hold mA / 50 (input), mA / 50 (charge)
  localparam int unsigned CHGCTL_ILIM_BIAS_MA = 500;
  localparam int unsigned CHGCTL_ICHG_BIAS_MA = 450;
  localparam int unsigned CHGCTL_ITO_BIAS_MA  = 25;
  localparam int unsigned CHGCTL_CUR_LSB_MA   = 50;

  // resistor index 0..8: 226k 178k 140k 110k 86.6k 69.8k 54.9k 39.2k 22.6k
  // top-off stops at 39.2k, termination voltage runs on down to 5.49k
  localparam int unsigned CHGCTL_CUR_RES_CNT = 9;
  localparam int unsigned CHGCTL_ITO_RES_CNT = 8;
  localparam int unsigned CHGCTL_TERMINATION_VOLTAGE_STRAP_RES_CNT = 15;

  // top-off field code for bias rail; resistor idx n maps to code n
  localparam logic [2:0] CHGCTL_ITO_BIAS_CODE = 3'h0;

  // termination voltage code: bias = 0x00, resistor idx n = n + 1
  localparam logic [7:0] CHGCTL_TERMINATION_VOLTAGE_STRAP_BIAS_CODE = 8'h00;

endpackage

// ---- verif/chgctl_chk.sv ----
`timescale 1ns/1ps
module chgctl_chk
  import chgctl_pkg::*;
(
  // clock and reset
  input wire logic           clk_sys_in,
  input wire logic           rst_in,
  // watched inputs
  input wire logic           otg_request_pin_in,
  input wire logic [3:0]     mode_field_in,
  input wire logic           battery_switch_disable_bit_in,
  input wire logic           standby_enable_bit_in,
  input wire logic           charge_event_irq_clear_in,
  input wire chgctl_thm_e    thermistor_input_in,
  input wire logic           wr_input_limit_in,
  input wire logic           wr_fast_charge_in,
  input wire logic           wr_topoff_in,
  input wire logic           wr_term_voltage_in,
  input wire chgctl_params_s wr_data_in,
  // watched outputs
  input wire logic           battery_system_switch_out,
  input wire logic           converter_enable_out,
  input wire logic           ship_mode_out,
  input wire logic           charge_enable_out,
  input wire logic           charge_timer_reset_out,
  input wire logic           charge_event_irq_out,
  input wire logic           charging_indicator_out,
  input wire logic           params_loaded_out,
  input wire chgctl_cfg_e    strap_config_out,
  input wire chgctl_params_s params_out
);
  // ====
  // helpers
  logic no_wr;
  assign no_wr = !(wr_input_limit_in | wr_fast_charge_in | wr_topoff_in | wr_term_voltage_in);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ====
  // assertions
  ship_off_a: assert property (
    ship_mode_out |-> !battery_system_switch_out && !converter_enable_out)
    else $error("ship mode with switch or converter on");
  otg_on_a: assert property (
    mode_field_in == CHGCTL_MODE_OTG |=> (battery_system_switch_out || ship_mode_out)
      && !charge_enable_out)
    else $error("reverse mode request not honoured");
  dis_bit_a: assert property (
    (!otg_request_pin_in)[*3] ##0 (battery_switch_disable_bit_in
      && mode_field_in != CHGCTL_MODE_OTG) |=> !battery_system_switch_out && !charge_enable_out)
    else $error("disabled switch still on or charging");
  standby_pin_bit_a: assert property (
    (!otg_request_pin_in)[*3] ##0 (standby_enable_bit_in
      && mode_field_in != CHGCTL_MODE_OTG) |=> !converter_enable_out)
    else $error("converter on during standby");
  irq_hold_a: assert property (
    charge_event_irq_out && !charge_event_irq_clear_in |=> charge_event_irq_out)
    else $error("event flag dropped without clear");
  irq_src_a: assert property (
    $rose(charge_event_irq_out) |-> charge_timer_reset_out && !charge_enable_out)
    else $error("event flag without suspension");
  rail_off_a: assert property (
    (thermistor_input_in == CHGCTL_THM_RAIL)[*3] |=> !charge_enable_out)
    else $error("charging with battery removed");
  abn_off_a: assert property (
    strap_config_out == CHGCTL_CFG_ABNORMAL |-> !charge_enable_out && !charging_indicator_out)
    else $error("charging with abnormal straps");
  prm_hold_a: assert property (
    (params_loaded_out && no_wr)[*2] |=> $stable(params_out))
    else $error("parameters changed without write");
  wr_ilim_a: assert property (
    params_loaded_out && wr_input_limit_in |-> ##2
      params_out.input_current_limit_field == $past(wr_data_in.input_current_limit_field, 2))
    else $error("input limit write not applied");
endmodule

bind chgctl_core chgctl_chk chk_u (.clk_sys_in, .rst_in, .otg_request_pin_in, .mode_field_in,
  .battery_switch_disable_bit_in, .standby_enable_bit_in, .charge_event_irq_clear_in,
  .thermistor_input_in, .wr_input_limit_in, .wr_fast_charge_in, .wr_topoff_in,
  .wr_term_voltage_in, .wr_data_in, .battery_system_switch_out, .converter_enable_out,
  .ship_mode_out, .charge_enable_out, .charge_timer_reset_out, .charge_event_irq_out,
  .charging_indicator_out, .params_loaded_out, .strap_config_out, .params_out);

// ---- verif/chgctl_host_model.sv ----
`timescale 1ns/1ps
module chgctl_host_model
  import chgctl_pkg::*;
(
  // clock
  input  wire logic      clk_sys_in,
  // strap resistors
  output chgctl_strap_s  ilim_out,
  output chgctl_strap_s  fast_charge_strap_out,
  output chgctl_strap_s  ito_out,
  output chgctl_strap_s  termination_voltage_strap_out,
  // host register writes
  output logic [3:0]     wr_out,
  output chgctl_params_s data_out
);
  initial begin
    wr_out = 4'h0;
    data_out = '0;
  end
  // straps only move while the device is held in reset
  task automatic straps(input chgctl_strap_s a, b, c, d);
    {ilim_out, fast_charge_strap_out, ito_out, termination_voltage_strap_out} = {a, b, c, d};
  endtask
  // one strobe cycle; data is inverted once released
  task automatic write(input logic [3:0] sel, input chgctl_params_s d);
    @(posedge clk_sys_in);
    #1;
    wr_out = sel;
    data_out = d;
    @(posedge clk_sys_in);
    #1;
    wr_out = 4'h0;
    data_out = ~d;
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
  import chgctl_pkg::*;
;
  logic           clk_sys_in = 1'b0;
  logic           rst_in     = 1'b1;
  logic           otg_p, dis_p, standby_pin_p, cin, dis_b, standby_pin_b, prof, chg_b, clr, pp_c, pp_s;
  logic           m, xs, xc, og, sh, sw, conv, ship, chg, tmr, pact, pres, good, irq, ind, ld;
  logic [3:0]     mode, wr, dtl;
  chgctl_thm_e    thermistor_input;
  chgctl_cfg_e    cfg;
  chgctl_strap_s  s_il, s_fc, s_to, s_vs;
  chgctl_params_s wd, prm, xp, d;
  int             fails, total_checks, mk, vr, sq[$], cur[9];
  logic [31:0]    me, mo, eq[$];
  event           ev;

  always #5 clk_sys_in = ~clk_sys_in;

  chgctl_core dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .otg_request_pin_in(otg_p), .battery_switch_disable_pin_in(dis_p),
    .standby_pin_in(standby_pin_p), .charger_input_valid_in(cin), .mode_field_in(mode),
    .battery_switch_disable_bit_in(dis_b), .standby_enable_bit_in(standby_pin_b),
    .temp_profile_enable_in(prof), .charge_enable_bit_in(chg_b),
    .charge_event_irq_clear_in(clr), .pp_converter_on_in(pp_c), .pp_switch_on_in(pp_s),
    .thermistor_input_in(thermistor_input), .input_limit_strap_in(s_il), .fast_charge_strap_in(s_fc),
    .topoff_strap_in(s_to), .termination_voltage_strap_in(s_vs),
    .wr_input_limit_in(wr[0]), .wr_fast_charge_in(wr[1]), .wr_topoff_in(wr[2]),
    .wr_term_voltage_in(wr[3]), .wr_data_in(wd),
    .battery_system_switch_out(sw), .converter_enable_out(conv), .ship_mode_out(ship),
    .charge_enable_out(chg), .charge_timer_reset_out(tmr), .temp_profile_active_out(pact),
    .battery_present_out(pres), .charge_detail_code_out(dtl), .charge_good_flag_out(good),
    .charge_event_irq_out(irq), .charging_indicator_out(ind), .params_loaded_out(ld),
    .strap_config_out(cfg), .params_out(prm));
  chgctl_host_model hm_u (.clk_sys_in(clk_sys_in), .ilim_out(s_il), .fast_charge_strap_out(s_fc),
    .ito_out(s_to), .termination_voltage_strap_out(s_vs), .wr_out(wr), .data_out(wd));

  // ====
  // scoreboard: item 0 sw 1 conv 2 ship 3 chg 4 tmr 5 pact 6 pres 7 dtl 8 good 9 irq
  // 10 ind 11 cfg 12 params 13 loaded
  function automatic logic [31:0] obs(input int k);
    logic [31:0] v[14];
    v = '{32'(sw), 32'(conv), 32'(ship), 32'(chg), 32'(tmr), 32'(pact), 32'(pres),
          32'(dtl), 32'(good), 32'(irq), 32'(ind), 32'(cfg), 32'(prm), 32'(ld)};
    return v[k];
  endfunction
  task automatic chk(input int k, input logic [31:0] v);
    sq.push_back(k);
    eq.push_back(v);
    ->ev;
  endtask
  always begin
    @(ev);
    while (sq.size() > 0) begin
      mk = sq.pop_front();
      me = eq.pop_front();
      mo = obs(mk);
      total_checks++;
      if (mo !== me) begin
        fails++;
        $display("CHECK FAILED time=%0t item=%0d exp=%0h got=%0h", $time, mk, me, mo);
      end
    end
  end
  // ====
  // helpers
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  function automatic chgctl_strap_s r(input int i);
    return {CHGCTL_STRAP_RES, 4'(i)};
  endfunction
  function automatic chgctl_params_s ex(input int i, input int v);
    return {7'(cur[i] / CHGCTL_CUR_LSB_MA), 1'b0, 8'(cur[8 - i] / CHGCTL_CUR_LSB_MA),
            3'(i), 8'(v + 1)};
  endfunction
  task automatic do_reset(input chgctl_strap_s a, b, c, e);
    rst_in = 1'b1;
    hm_u.straps(a, b, c, e);
    w(2);
    rst_in = 1'b0;
    w(3);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    final_report();
  end
  // ====
  // tests
  initial begin
    {otg_p, dis_p, standby_pin_p, dis_b, standby_pin_b, clr, pp_c, pp_s, m} = '0;
    {cin, chg_b, prof} = 3'h7;
    mode = 4'h0;
    thermistor_input = CHGCTL_THM_NORMAL;
    fails = 0;
    total_checks = 0;
    cur = '{50, 100, 200, 500, 1000, 1500, 2000, 2500, 3000};
    void'($urandom(32'hAE6E));
    for (int i = 0; i < 9; i++) begin
      vr = $urandom_range(0, 14);
      do_reset(r(i), r(8 - i), r(i % 8), r(vr));
      chk(11, 32'(CHGCTL_CFG_RESISTOR));
      chk(12, 32'(ex(i, vr)));
      chk(13, 1);
    end
    do_reset('0, '0, '0, '0);
    chk(11, 32'(CHGCTL_CFG_DEFAULT));
    chk(12, {5'h0, 7'(CHGCTL_ILIM_BIAS_MA / CHGCTL_CUR_LSB_MA), 1'b0,
             8'(CHGCTL_ICHG_BIAS_MA / CHGCTL_CUR_LSB_MA), CHGCTL_ITO_BIAS_CODE, CHGCTL_TERMINATION_VOLTAGE_STRAP_BIAS_CODE});
    for (int k = 0; k < 4; k++) begin
      do_reset({chgctl_strap_kind_e'(2'(k)), 4'hF}, r(1), r(2), r(3));
      chk(11, 32'(CHGCTL_CFG_ABNORMAL));
      chk(3, 0);
      chk(10, 0);
    end
    $display("test done: straps");
    do_reset(r(3), r(5), r(3), r(5));
    d = chgctl_params_s'(27'($urandom));
    hm_u.write(4'hF, d);
    w(1);
    chk(12, 32'(d));
    xp = d;
    d = chgctl_params_s'(27'($urandom));
    hm_u.write(4'h4, d);
    w(1);
    xp.topoff_threshold_field = d.topoff_threshold_field;
    chk(12, 32'(xp));
    do_reset(r(3), r(5), r(3), r(5));
    chk(12, 32'(ex(3, 5)));
    $display("test done: host writes");
    for (int c = 0; c < 128; c++) begin
      {otg_p, m, dis_p, dis_b, cin, standby_pin_p, standby_pin_b} = 7'(c);
      mode = m ? CHGCTL_MODE_OTG : 4'($urandom_range(0, 9));
      {pp_c, pp_s} = 2'($urandom);
      w(4);
      og = otg_p | m;
      sh = dis_p & ~cin & ~standby_pin_p;
      if (sh) {xs, xc} = 2'b00;
      else if (og) {xs, xc} = {1'b1, pp_c};
      else if (dis_p | dis_b) {xs, xc} = {1'b0, pp_c & ~(standby_pin_p | standby_pin_b)};
      else if (standby_pin_p | standby_pin_b) {xs, xc} = 2'b10;
      else {xs, xc} = {pp_s, pp_c};
      chk(0, 32'(xs));
      chk(1, 32'(xc));
      chk(2, 32'(sh));
      if (sh | og | dis_p | dis_b) chk(3, 0);
    end
    $display("test done: switch control");
    {otg_p, dis_p, dis_b, standby_pin_p, standby_pin_b, m} = '0;
    mode = 4'h0;
    cin = 1'b1;
    w(4);
    chk(3, 1);
    chk(5, 1);
    chk(7, 32'(CHGCTL_DTL_CHARGING));
    chk(8, 1);
    chk(10, 1);
    for (int t = 1; t < 3; t++) begin
      thermistor_input = chgctl_thm_e'(3'(t));
      w(4);
      chk(3, 0);
      chk(4, 1);
      chk(7, 32'(CHGCTL_DTL_THM_SUSP));
      chk(8, 0);
      chk(9, 1);
      clr = 1'b1;
      w(1);
      clr = 1'b0;
      thermistor_input = CHGCTL_THM_NORMAL;
      w(4);
      chk(9, 0);
      chk(3, 1);
      chk(4, 0);
    end
    prof = 1'b0;
    w(2);
    chk(5, 0);
    {prof, chg_b} = 2'b10;
    thermistor_input = CHGCTL_THM_GROUND;
    w(4);
    chk(5, 0);
    chk(6, 1);
    chk(3, 1);
    chg_b = 1'b1;
    thermistor_input = CHGCTL_THM_RAIL;
    w(4);
    chk(6, 0);
    chk(3, 0);
    $display("test done: thermistor");
    w(2);
    final_report();
  end
endmodule
